/* fsp_pkg.sv */
// Shared constants and types for the flash self-programming link
package fsp_pkg;
   // Control register bit positions
   localparam int CTL_CLR_BUF   = 4;
   localparam int CTL_RD_FUSE   = 3;
   localparam int CTL_PG_WRITE  = 2;
   localparam int CTL_PG_ERASE  = 1;
   localparam int CTL_SPM_EN    = 0;
   localparam int CTL_CMD_W     = 5;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Command patterns in the low five control bits
   localparam logic [4:0] PAT_CLR   = 5'h11;
   localparam logic [4:0] PAT_FUSE  = 5'h09;
   localparam logic [4:0] PAT_WRITE = 5'h05;
   localparam logic [4:0] PAT_ERASE = 5'h03;
   localparam logic [4:0] PAT_LOAD  = 5'h01;
   // Arming windows in clock cycles
   localparam logic [2:0] ARM_CYC    = 3'h4;
   localparam logic [2:0] RD_ARM_CYC = 3'h3;
   localparam logic [2:0] RD_LAST    = ARM_CYC - RD_ARM_CYC + 3'h1;
   // Pointer values for fuse and lock reads
   localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
   localparam logic [15:0] PTR_LOCK    = 16'h0001;
   localparam logic [15:0] PTR_FUSE_HI = 16'h0003;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [7:0]  NO_FUSE     = 8'hff;
   // Programming time
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real PROG_MIN_MS   = 3.7;
   localparam real PROG_MAX_MS   = 4.5;
   localparam int  PROG_MIN_CYC  =
      int'($ceil(PROG_MIN_MS * 1.0e6 / CLK_PERIOD_NS - 1.0e-6));
   localparam int  PROG_MAX_CYC  =
      int'($floor(PROG_MAX_MS * 1.0e6 / CLK_PERIOD_NS + 1.0e-6));
   // Controller register map (byte offsets)
   localparam logic [3:0] REG_CMD  = 4'h0;
   localparam logic [3:0] REG_PTR  = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STAT = 4'hc;
   localparam int ST_BUSY = 0;
   localparam int ST_ERR  = 1;
   localparam int ST_STALL = 2;
   // Controller opcodes in command bits 2:0, fuse select in bits 5:4
   localparam logic [2:0] OP_LOAD  = 3'h1;
   localparam logic [2:0] OP_ERASE = 3'h2;
   localparam logic [2:0] OP_WRITE = 3'h3;
   localparam logic [2:0] OP_CLEAR = 3'h4;
   localparam logic [2:0] OP_FUSE  = 3'h5;
   localparam logic [2:0] OP_READ  = 3'h6;
   localparam logic [1:0] SEL_LOW  = 2'h0;
   localparam logic [1:0] SEL_LOCK = 2'h1;
   localparam logic [1:0] SEL_HIGH = 2'h2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {OPS_IDLE, OPS_ERASE, OPS_WRITE} fsp_op_e;
   typedef enum logic [1:0] {HS_IDLE, HS_CTRL, HS_ISSUE, HS_WAIT} fsp_host_e;
endpackage

/* fsp_link_if.sv */
// Link between the CPU-side controller and the self-programming device
`timescale 1ns/1ns
interface fsp_link_if;
   logic        ctl_we;
   logic [7:0]  ctl_wdata;
   logic [7:0]  ctl_rdata;
   logic        store_req;
   logic        load_req;
   logic [15:0] pointer;
   logic [15:0] data_word;
   logic        stall;
   logic [7:0]  load_data;
   logic        load_valid;
   modport dev (
      input  ctl_we, ctl_wdata, store_req, load_req, pointer, data_word,
      output ctl_rdata, stall, load_data, load_valid
   );
   modport cpu (
      output ctl_we, ctl_wdata, store_req, load_req, pointer, data_word,
      input  ctl_rdata, stall, load_data, load_valid
   );
endinterface

/* fsp_dev.sv */
// Flash self-programming device: control register, page buffer, flash array
`timescale 1ns/1ns
module fsp_dev
   import fsp_pkg::*;
#(
   parameter int FLASH_WORDS = 1024,
   parameter int PAGE_WORDS  = 16,
   parameter int PROG_CYC    = PROG_MIN_CYC
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_b,
   fsp_link_if.dev         lnk,
   input  wire logic       i_eeprom_busy,
   input  wire logic [7:0] i_lock_bits,
   input  wire logic [7:0] i_fuse_low,
   input  wire logic [7:0] i_fuse_high,
   output logic            o_prog_busy
);

   // Word and page field widths of the byte pointer, and the width of the programming timer
   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PB = $clog2(FLASH_WORDS / PAGE_WORDS);
   localparam int CW = $clog2(PROG_CYC + 1);

   if (PAGE_WORDS < 2 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 ||
       FLASH_WORDS < 2 * PAGE_WORDS || (FLASH_WORDS & (FLASH_WORDS - 1)) != 0 ||
       FLASH_WORDS > 32768 || PROG_CYC < PROG_MIN_CYC || PROG_CYC > PROG_MAX_CYC)
   begin : g_bad_cfg
      $error("fsp_dev: unsupported geometry or programming time");
   end

   logic [4:0]        ctl_ff;
   logic [2:0]        win_ff;
   fsp_op_e           op_ff;
   logic [CW-1:0]     op_cnt_ff;
   logic [PB-1:0]     op_page_ff;
   logic              stall_ff;
   logic [7:0]        load_data_ff;
   logic              load_valid_ff;
   logic [15:0]       flash_mem [FLASH_WORDS];
   logic [15:0]       pbuf_mem  [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] loaded_ff;

   logic [WB-1:0]     word_idx;
   logic [PB-1:0]     page_idx;
   logic [PB+WB-1:0]  rd_word_addr;
   logic              pat_legal;
   logic              ctl_wr;
   logic              idle;
   logic              armed;
   logic              spm_go;
   logic              fuse_go;
   logic              op_done;
   logic              buf_clear;
   logic [15:0]       rd_word;

   // Pointer split: low bits pick the word, high bits the page
   assign word_idx     = lnk.pointer[WB:1];
   assign page_idx     = lnk.pointer[WB+PB:WB+1];
   assign rd_word_addr = lnk.pointer[WB+PB:1];

   assign idle = (op_ff == OPS_IDLE);

   always_comb begin
      case (lnk.ctl_wdata[4:0])
         PAT_CLR, PAT_FUSE, PAT_WRITE, PAT_ERASE, PAT_LOAD: pat_legal = 1'b1;
         default: pat_legal = 1'b0;
      endcase
   end

   // An EEPROM write in progress locks the command register out
   assign ctl_wr = lnk.ctl_we && pat_legal && idle && !i_eeprom_busy;

   assign armed   = ctl_ff[CTL_SPM_EN] && (win_ff != 3'h0) && idle;
   assign spm_go  = armed && lnk.store_req && !i_eeprom_busy;
   assign fuse_go = armed && ctl_ff[CTL_RD_FUSE] && (win_ff >= RD_LAST) &&
                    lnk.load_req && !i_eeprom_busy;
   assign op_done = !idle && (op_cnt_ff == '0);

   // Control register and arming window
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ctl_ff <= CTL_RESET[4:0];
         win_ff <= 3'h0;
      end else if (ctl_wr) begin
         ctl_ff <= lnk.ctl_wdata[4:0];
         win_ff <= ARM_CYC;
      end else if (op_done) begin
         ctl_ff <= 5'h00;
         win_ff <= 3'h0;
      end else if (!idle) begin
         win_ff <= 3'h0;
      end else if (spm_go) begin
         // Erase and write keep their bits until the operation ends
         if (ctl_ff != PAT_ERASE && ctl_ff != PAT_WRITE) begin
            ctl_ff <= 5'h00;
         end
         win_ff <= 3'h0;
      end else if (fuse_go) begin
         ctl_ff <= 5'h00;
         win_ff <= 3'h0;
      end else if (win_ff == 3'h1 ||
                   (ctl_ff[CTL_RD_FUSE] && win_ff == RD_LAST)) begin
         ctl_ff <= 5'h00;
         win_ff <= 3'h0;
      end else if (win_ff != 3'h0) begin
         win_ff <= win_ff - 3'h1;
      end
   end

   assign lnk.ctl_rdata = {3'h0, ctl_ff};

   // Erase / write sequencer; timing stands in for the internal oscillator
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         op_ff      <= OPS_IDLE;
         op_cnt_ff  <= '0;
         op_page_ff <= '0;
      end else if (spm_go && ctl_ff == PAT_ERASE) begin
         op_ff      <= OPS_ERASE;
         op_page_ff <= page_idx;
         op_cnt_ff  <= CW'(PROG_CYC - 1);
      end else if (spm_go && ctl_ff == PAT_WRITE) begin
         op_ff      <= OPS_WRITE;
         op_page_ff <= page_idx;
         op_cnt_ff  <= CW'(PROG_CYC - 1);
      end else if (op_done) begin
         op_ff <= OPS_IDLE;
      end else if (!idle) begin
         op_cnt_ff <= op_cnt_ff - CW'(1);
      end
   end

   // The CPU stays halted from the cycle after the store to the end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         stall_ff <= 1'b0;
      end else if (spm_go && (ctl_ff == PAT_ERASE || ctl_ff == PAT_WRITE)) begin
         stall_ff <= 1'b1;
      end else if (op_done) begin
         stall_ff <= 1'b0;
      end
   end

   assign lnk.stall = stall_ff;
   assign o_prog_busy = stall_ff;

   // Flash array holds no reset: it models non-volatile storage
   always_ff @(posedge i_sys_clk) begin
      if (op_done && op_ff == OPS_ERASE) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            flash_mem[{op_page_ff, i[WB-1:0]}] <= ERASED_WORD;
         end
      end else if (op_done && op_ff == OPS_WRITE) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            flash_mem[{op_page_ff, i[WB-1:0]}] <= pbuf_mem[i];
         end
      end
   end

   // Any EEPROM activity while words sit in the buffer throws them away
   assign buf_clear = (op_done && op_ff == OPS_WRITE) ||
                      (ctl_wr && lnk.ctl_wdata[4:0] == PAT_CLR) ||
                      (i_eeprom_busy && (loaded_ff != '0));

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b || buf_clear) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            pbuf_mem[i] <= ERASED_WORD;
         end
         loaded_ff <= '0;
      end else if (spm_go && ctl_ff == PAT_LOAD && !loaded_ff[word_idx]) begin
         // A second load to the same slot is dropped
         pbuf_mem[word_idx]  <= lnk.data_word;
         loaded_ff[word_idx] <= 1'b1;
      end
   end

   // Load answers one cycle later with a flash byte or a fuse/lock byte
   assign rd_word = flash_mem[rd_word_addr];

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         load_valid_ff <= 1'b0;
         load_data_ff  <= 8'h00;
      end else begin
         load_valid_ff <= lnk.load_req && idle;
         if (fuse_go) begin
            case (lnk.pointer[1:0])
               PTR_FUSE_LO[1:0]: load_data_ff <= i_fuse_low;
               PTR_LOCK[1:0]:    load_data_ff <= i_lock_bits;
               PTR_FUSE_HI[1:0]: load_data_ff <= i_fuse_high;
               default:          load_data_ff <= NO_FUSE;
            endcase
         end else if (lnk.load_req && idle) begin
            load_data_ff <= lnk.pointer[0] ? rd_word[15:8] : rd_word[7:0];
         end
      end
   end

   assign lnk.load_data  = load_data_ff;
   assign lnk.load_valid = load_valid_ff;

endmodule

/* fsp_host.sv */
// CPU-side controller: AXI4-Lite registers driving the self-programming link
`timescale 1ns/1ns
module fsp_host
   import fsp_pkg::*;
#(
   parameter int FLASH_WORDS = 1024,
   parameter int PAGE_WORDS  = 16,
   parameter int AXI_ADDR_W  = 4
) (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst_b,
   fsp_link_if.cpu                    lnk,
   input  wire logic                  i_s_axi_awvalid,
   output logic                       o_s_axi_awready,
   input  wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic                  i_s_axi_wvalid,
   output logic                       o_s_axi_wready,
   input  wire logic [31:0]           i_s_axi_wdata,
   input  wire logic [3:0]            i_s_axi_wstrb,
   output logic                       o_s_axi_bvalid,
   input  wire logic                  i_s_axi_bready,
   output logic [1:0]                 o_s_axi_bresp,
   input  wire logic                  i_s_axi_arvalid,
   output logic                       o_s_axi_arready,
   input  wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
   output logic                       o_s_axi_rvalid,
   input  wire logic                  i_s_axi_rready,
   output logic [31:0]                o_s_axi_rdata,
   output logic [1:0]                 o_s_axi_rresp
);

   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PB = $clog2(FLASH_WORDS / PAGE_WORDS);
   localparam logic [15:0] PAGE_MASK = 16'(((1 << PB) - 1) << (WB + 1));

   if (AXI_ADDR_W < 4 || PAGE_WORDS < 2 || WB + PB > 15) begin : g_bad_cfg
      $error("fsp_host: unsupported parameters");
   end

   logic aw_rdy_ff, aw_have_ff, w_rdy_ff, w_have_ff, bvalid_ff;
   logic ar_rdy_ff, rvalid_ff, err_ff;
   logic [AXI_ADDR_W-1:0] aw_addr_ff;
   logic [31:0] w_data_ff, rdata_ff;
   logic [3:0]  w_strb_ff;
   logic [1:0]  bresp_ff, rresp_ff;
   logic [15:0] ptr_ff, data_ff, ptr_out_ff, data_out_ff;
   logic [7:0]  ctl_out_ff, rd_byte_ff;
   logic        ctl_we_ff, store_ff, load_ff;
   logic [2:0]  op_ff;
   logic [PAGE_WORDS-1:0] mask_ff;
   fsp_host_e   st_ff;
   logic        do_wr, wr_ok, cmd_wr, cmd_ok;
   logic [2:0]  op;
   logic [1:0]  sel;
   logic [3:0]  wa;

   function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
      return (a >> 4) == '0 && a[1:0] == 2'h0;
   endfunction

   function automatic logic [4:0] pattern(input logic [2:0] o);
      case (o)
         OP_LOAD:  return PAT_LOAD;
         OP_ERASE: return PAT_ERASE;
         OP_WRITE: return PAT_WRITE;
         OP_CLEAR: return PAT_CLR;
         OP_FUSE:  return PAT_FUSE;
         default:  return 5'h00;
      endcase
   endfunction

   // Write address and data are taken independently, answered together
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         aw_rdy_ff <= 1'b0; aw_have_ff <= 1'b0; aw_addr_ff <= '0;
         w_rdy_ff <= 1'b0; w_have_ff <= 1'b0; w_data_ff <= 32'h0; w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0; bresp_ff <= RESP_OKAY;
      end else begin
         if (aw_rdy_ff && i_s_axi_awvalid) begin
            aw_rdy_ff <= 1'b0; aw_have_ff <= 1'b1; aw_addr_ff <= i_s_axi_awaddr;
         end else if (!aw_have_ff && !bvalid_ff) begin
            aw_rdy_ff <= 1'b1;
         end
         if (w_rdy_ff && i_s_axi_wvalid) begin
            w_rdy_ff <= 1'b0; w_have_ff <= 1'b1;
            w_data_ff <= i_s_axi_wdata; w_strb_ff <= i_s_axi_wstrb;
         end else if (!w_have_ff && !bvalid_ff) begin
            w_rdy_ff <= 1'b1;
         end
         if (do_wr) begin
            aw_have_ff <= 1'b0; w_have_ff <= 1'b0; bvalid_ff <= 1'b1;
            bresp_ff <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_ff && i_s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   assign do_wr  = aw_have_ff && w_have_ff && !bvalid_ff;
   assign wa     = aw_addr_ff[3:0];
   assign wr_ok  = do_wr && mapped(aw_addr_ff);
   assign cmd_wr = wr_ok && wa == REG_CMD && w_strb_ff[0];
   assign op     = w_data_ff[2:0];
   assign sel    = w_data_ff[5:4];
   // Refuse a reload of a filled slot and anything while busy
   assign cmd_ok = cmd_wr && st_ff == HS_IDLE && op >= OP_LOAD && op <= OP_READ &&
                   !(op == OP_LOAD && mask_ff[ptr_ff[WB:1]]);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ptr_ff <= 16'h0000; data_ff <= 16'h0000; err_ff <= 1'b0; mask_ff <= '0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (wr_ok && wa == REG_PTR && w_strb_ff[b]) ptr_ff[8*b +: 8] <= w_data_ff[8*b +: 8];
            if (wr_ok && wa == REG_DATA && w_strb_ff[b]) data_ff[8*b +: 8] <= w_data_ff[8*b +: 8];
         end
         if (cmd_wr && !cmd_ok) begin
            err_ff <= 1'b1;
         end else if (wr_ok && wa == REG_STAT && w_strb_ff[0] && w_data_ff[ST_ERR]) begin
            err_ff <= 1'b0;
         end
         if (cmd_ok && (op == OP_CLEAR || op == OP_WRITE)) begin
            mask_ff <= '0;
         end else if (cmd_ok && op == OP_LOAD) begin
            mask_ff[ptr_ff[WB:1]] <= 1'b1;
         end
      end
   end

   // Command sequencer: arm the control register, then issue within the window
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         st_ff <= HS_IDLE; op_ff <= 3'h0; ctl_we_ff <= 1'b0; ctl_out_ff <= CTL_RESET;
         store_ff <= 1'b0; load_ff <= 1'b0; ptr_out_ff <= 16'h0000;
         data_out_ff <= 16'h0000; rd_byte_ff <= 8'h00;
      end else begin
         case (st_ff)
            HS_IDLE: if (cmd_ok) begin
               op_ff       <= op;
               ctl_we_ff   <= (op != OP_READ);
               ctl_out_ff  <= {3'h0, pattern(op)};
               data_out_ff <= data_ff;
               st_ff       <= HS_CTRL;
               if (op == OP_WRITE) begin
                  ptr_out_ff <= ptr_ff & PAGE_MASK;
               end else if (op == OP_FUSE) begin
                  ptr_out_ff <= (sel == SEL_LOCK) ? PTR_LOCK :
                                (sel == SEL_HIGH) ? PTR_FUSE_HI : PTR_FUSE_LO;
               end else begin
                  ptr_out_ff <= ptr_ff;
               end
            end
            HS_CTRL: begin
               ctl_we_ff <= 1'b0;
               // Issued one cycle after the control write, inside every window
               store_ff  <= (op_ff == OP_LOAD || op_ff == OP_ERASE ||
                             op_ff == OP_WRITE);
               load_ff   <= (op_ff == OP_FUSE || op_ff == OP_READ);
               st_ff     <= HS_ISSUE;
            end
            HS_ISSUE: begin
               store_ff <= 1'b0;
               load_ff  <= 1'b0;
               // Stall and load answer only show a cycle after the issue
               st_ff    <= HS_WAIT;
            end
            HS_WAIT: begin
               if (lnk.load_valid) rd_byte_ff <= lnk.load_data;
               if (!lnk.stall) st_ff <= HS_IDLE;
            end
            default: st_ff <= HS_IDLE;
         endcase
      end
   end

   // Register read port
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ar_rdy_ff <= 1'b0; rvalid_ff <= 1'b0; rdata_ff <= 32'h0; rresp_ff <= RESP_OKAY;
      end else if (ar_rdy_ff && i_s_axi_arvalid) begin
         ar_rdy_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff  <= mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (i_s_axi_araddr[3:0])
            REG_CMD:  rdata_ff <= {29'h0, op_ff};
            REG_PTR:  rdata_ff <= {16'h0, ptr_ff};
            REG_DATA: rdata_ff <= {16'h0, data_ff};
            REG_STAT: rdata_ff <= {8'h0, lnk.ctl_rdata, rd_byte_ff, 5'h0,
                                   lnk.stall, err_ff, st_ff != HS_IDLE};
            default:  rdata_ff <= 32'h0;
         endcase
         if (!mapped(i_s_axi_araddr)) rdata_ff <= 32'h0;
      end else if (rvalid_ff && i_s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end else if (!rvalid_ff) begin
         ar_rdy_ff <= 1'b1;
      end
   end

   assign o_s_axi_awready = aw_rdy_ff;
   assign o_s_axi_wready  = w_rdy_ff;
   assign o_s_axi_bvalid  = bvalid_ff;
   assign o_s_axi_bresp   = bresp_ff;
   assign o_s_axi_arready = ar_rdy_ff;
   assign o_s_axi_rvalid  = rvalid_ff;
   assign o_s_axi_rdata   = rdata_ff;
   assign o_s_axi_rresp   = rresp_ff;
   assign lnk.ctl_we      = ctl_we_ff;
   assign lnk.ctl_wdata   = ctl_out_ff;
   assign lnk.store_req   = store_ff;
   assign lnk.load_req    = load_ff;
   assign lnk.pointer     = ptr_out_ff;
   assign lnk.data_word   = data_out_ff;

endmodule

/* fsp_link_sva.sv */
// Checker for the self-programming link between host and device
`timescale 1ns/1ns
module fsp_link_sva
   import fsp_pkg::*;
(
   input wire logic       i_sys_clk,
   input wire logic       i_rst_b,
   input wire logic       i_eeprom_busy,
   input wire logic       ctl_we,
   input wire logic [7:0] ctl_wdata,
   input wire logic [7:0] ctl_rdata,
   input wire logic       store_req,
   input wire logic       load_req,
   input wire logic       stall,
   input wire logic       load_valid
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   wire ok = !i_eeprom_busy && !stall;
   rsv_zero_a: assert property (ctl_rdata[7:5] == 3'h0)
      else $error("reserved control bits not zero");
   erase_arm_a: assert property (ctl_we && ctl_wdata[4:0] == PAT_ERASE && ok
      |=> ctl_rdata[4:0] == PAT_ERASE) else $error("erase not armed");
   fuse_arm_a: assert property (ctl_we && ctl_wdata[4:0] == PAT_FUSE && ok
      |=> ctl_rdata[4:0] == PAT_FUSE) else $error("fuse read not armed");
   erase_stall_a: assert property (ctl_rdata[4:0] == PAT_ERASE && store_req && ok
      |=> stall [*2]) else $error("erase did not stall");
   stall_hold_a: assert property (stall |-> ctl_rdata[0] == 1'b1)
      else $error("enable dropped during operation");
   load_done_a: assert property (ctl_rdata[4:0] == PAT_LOAD && store_req && ok
      |=> ctl_rdata == 8'h00) else $error("enable not cleared after store");
   fuse_ans_a: assert property (ctl_rdata[4:0] == PAT_FUSE && load_req && ok
      |=> load_valid) else $error("fuse read gave no answer");
   ee_block_a: assert property (ctl_we && i_eeprom_busy && ctl_rdata == 8'h00
      |=> (ctl_rdata == 8'h00) [*3]) else $error("command taken during eeprom write");
   load_cause_a: assert property (load_valid |-> $past(load_req))
      else $error("load answer without request");
   cover property (ctl_we && ctl_wdata[4:0] == PAT_LOAD);
   cover property ($rose(stall));
   cover property (ctl_we && i_eeprom_busy);
endmodule

/* flash_self_program_ctrl_tb.sv */
// Self-checking bench: host controller and device joined by the link
`timescale 1ns/1ns
module flash_self_program_ctrl_tb
   import fsp_pkg::*;
;
   logic clk = 0, rst_b = 0, ee = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wr_rdy, bv, arr, rv, busy;
   logic [3:0] aa = 0, ra = 0;
   logic [31:0] wd = 0, rd_d, rq;
   logic [1:0] bresp, rresp, rsp;
   int errors = 0, tests_run = 0, cyc = 0;
   fsp_link_if lnk ();
   fsp_dev u_fsp_dev (.i_sys_clk(clk), .i_rst_b(rst_b), .lnk(lnk), .i_eeprom_busy(ee),
      .i_lock_bits(8'h5a), .i_fuse_low(8'ha5), .i_fuse_high(8'h3c), .o_prog_busy(busy));
   fsp_host u_fsp_host (.i_sys_clk(clk), .i_rst_b(rst_b), .lnk(lnk),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(aa),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .i_s_axi_wdata(wd),
      .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
      .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .i_s_axi_araddr(ra), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
      .o_s_axi_rdata(rd_d), .o_s_axi_rresp(rresp));
   fsp_link_sva u_fsp_link_sva (.i_sys_clk(clk), .i_rst_b(rst_b), .i_eeprom_busy(ee),
      .ctl_we(lnk.ctl_we), .ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata),
      .store_req(lnk.store_req), .load_req(lnk.load_req), .stall(lnk.stall),
      .load_valid(lnk.load_valid));
   always #5 clk = ~clk;
   // Whole run is under two hundred cycles; the long erase is only started, never waited out
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      aa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wr_rdy) wv <= 0;
      end while (!bv);
      rsp = bresp;
   endtask
   task automatic rd(input logic [3:0] a);
      ra <= a; arv <= 1; rr <= 1;
      do begin
         @(posedge clk);
         if (arr) arv <= 0;
      end while (!rv);
      rq = rd_d; rsp = rresp;
   endtask
   task automatic t_reset();
      rd(REG_STAT);
      chk(rq[23:16], CTL_RESET);
      chk(busy, 1'b0);
      rd(4'h2);
      chk(rsp, RESP_SLVERR);
      wr(4'h6, 32'h0000_0003);
      chk(rsp, RESP_SLVERR);
      $display("reset test done");
   endtask
   task automatic t_fuse();
      logic [7:0] exp [3] = '{8'ha5, 8'h5a, 8'h3c};
      for (int i = 0; i < 3; i++) begin
         wr(REG_CMD, {26'h0, i[1:0], 1'b0, OP_FUSE});
         repeat (3) @(posedge clk);
         rd(REG_STAT);
         chk(rq[15:8], exp[i]);
      end
      ee <= 1;
      wr(REG_CMD, {26'h0, SEL_LOCK, 1'b0, OP_FUSE});
      repeat (3) @(posedge clk);
      rd(REG_STAT);
      // A blocked read answers with a flash byte, never the lock byte
      chk(32'(rq[15:8] === 8'h5a), 32'h0);
      ee <= 0;
      $display("fuse test done");
   endtask
   task automatic t_load();
      wr(REG_PTR, 32'h0002);
      wr(REG_DATA, 32'h1234);
      wr(REG_CMD, {29'h0, OP_LOAD});
      rd(REG_STAT);
      chk(rq[1], 1'b0);
      wr(REG_PTR, 32'h0003);
      wr(REG_CMD, {29'h0, OP_LOAD});
      rd(REG_STAT);
      chk(rq[1], 1'b1);
      wr(REG_STAT, 32'h2);
      wr(REG_CMD, {29'h0, OP_CLEAR});
      wr(REG_CMD, {29'h0, OP_LOAD});
      rd(REG_STAT);
      chk(rq[1], 1'b0);
      $display("load test done");
   endtask
   task automatic t_erase();
      wr(REG_PTR, 32'h0040);
      wr(REG_CMD, {29'h0, OP_ERASE});
      // Stall rises two cycles after the write is answered
      repeat (2) @(posedge clk);
      rd(REG_STAT);
      chk(rq[2], 1'b1);
      chk(rq[0], 1'b1);
      chk(rq[23:16], {3'h0, PAT_ERASE});
      chk(busy, 1'b1);
      wr(REG_CMD, {29'h0, OP_READ});
      rd(REG_STAT);
      chk(rq[1], 1'b1);
      $display("erase test done");
   endtask
   task automatic test_done();
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      t_reset();
      t_fuse();
      t_load();
      t_erase();
      test_done();
   end
endmodule
